// File: dic_cap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dic_cap_if;
  logic        home_level;
  logic [31:0] pos_user;
  logic [31:0] pos_raw;
  logic [31:0] wdata;
  logic        ctrl_wr;
  logic        count_wr;
  logic        user_wr;
  logic        raw_wr;
  logic [31:0] ctrl;
  logic [31:0] count;
  logic [31:0] cap_user;
  logic [31:0] cap_raw;
  logic        pulse;

  modport owner (
    output home_level, pos_user, pos_raw, wdata, ctrl_wr, count_wr, user_wr, raw_wr,
    input  ctrl, count, cap_user, cap_raw, pulse
  );
  modport unit (
    input  home_level, pos_user, pos_raw, wdata, ctrl_wr, count_wr, user_wr, raw_wr,
    output ctrl, count, cap_user, cap_raw, pulse
  );
endinterface : dic_cap_if
`default_nettype wire

// File: dic_home_capture.sv
`timescale 1ns/1ps
`default_nettype none
module dic_home_capture (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic ce,
  dic_cap_if.unit   cap
);

  dic_pkg::dic_cap_state_t s_reg;
  dic_pkg::dic_cap_state_t s_next;
  dic_pkg::dic_cap_mode_t  mode;
  logic                    rise;
  logic                    fall;
  logic                    hit;
  logic                    start_wr;

  // ************************************************************
  // edge qualification and capture
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    rise   = cap.home_level & ~s_reg.home_q;
    fall   = ~cap.home_level & s_reg.home_q;
    // values above 3 behave as off
    mode   = (s_reg.ctrl[31:2] == '0) ? dic_pkg::dic_cap_mode_t'(s_reg.ctrl[1:0])
                                      : dic_pkg::CAP_OFF;
    unique case (mode)
      dic_pkg::CAP_RISE: hit = rise;
      dic_pkg::CAP_FALL: hit = fall;
      dic_pkg::CAP_BOTH: hit = rise | fall;
      dic_pkg::CAP_OFF:  hit = 1'b0;
    endcase
    start_wr = cap.ctrl_wr && (cap.wdata[31:2] == '0) && (cap.wdata[1:0] != 2'h0);
    s_next.home_q = cap.home_level;
    s_next.pulse  = hit;
    if (cap.ctrl_wr) begin
      s_next.ctrl = cap.wdata;
    end
    if (cap.count_wr) begin
      s_next.count = cap.wdata;
    end
    if (start_wr) begin
      s_next.count = dic_pkg::RST_WORD;
    end
    if (cap.user_wr) begin
      s_next.cap_user = cap.wdata;
    end
    if (cap.raw_wr) begin
      s_next.cap_raw = cap.wdata;
    end
    // a capture in the clearing cycle is still counted
    if (hit) begin
      s_next.count    = s_next.count + 32'h0000_0001;
      s_next.cap_user = cap.pos_user;
      s_next.cap_raw  = cap.pos_raw;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg <= dic_pkg::CAP_STATE_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign cap.ctrl     = s_reg.ctrl;
  assign cap.count    = s_reg.count;
  assign cap.cap_user = s_reg.cap_user;
  assign cap.cap_raw  = s_reg.cap_raw;
  assign cap.pulse    = s_reg.pulse;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_rise_capture: assert property (ce && s_reg.ctrl == 32'h0000_0001 && rise && !cap.ctrl_wr
      && !cap.count_wr |=> cap.count == $past(s_reg.count) + 32'h0000_0001
      && cap.cap_user == $past(cap.pos_user) && cap.cap_raw == $past(cap.pos_raw))
    else $error("rising edge not captured");
  a_fall_ignored: assert property (ce && s_reg.ctrl == 32'h0000_0001 && fall
      && !cap.ctrl_wr && !cap.count_wr |=> $stable(cap.count))
    else $error("falling edge counted in rising mode");
  a_off_holds: assert property (ce && s_reg.ctrl == 32'h0000_0000 && !cap.ctrl_wr
      && !cap.count_wr ##1 ce && !cap.ctrl_wr && !cap.count_wr |=> $stable(cap.count))
    else $error("count moved while capture off");
  a_start_clears: assert property (ce && start_wr && !(rise || fall)
      |=> cap.count == 32'h0000_0000 && cap.ctrl == $past(cap.wdata))
    else $error("count not cleared on start");

  c_both_edges: cover property (ce && s_reg.ctrl == 32'h0000_0003 && hit ##[1:20] hit);
  c_fall_hit:   cover property (ce && s_reg.ctrl == 32'h0000_0002 && hit);

endmodule : dic_home_capture
`default_nettype wire

// File: dic_input_cond.sv
`timescale 1ns/1ps
`default_nettype none
module dic_input_cond (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [31:0] din_pin,
  input  wire logic [31:0] pos_user,
  input  wire logic [31:0] pos_raw,
  input  wire logic        od_req,
  input  wire logic        od_wr,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_sub,
  input  wire logic [31:0] od_wdata,
  output logic      [31:0] od_rdata,
  output logic             od_ack,
  output logic             od_abort,
  output logic      [31:0] processed_input_word,
  output logic             neg_limit_active,
  output logic             pos_limit_active,
  output logic             home_active,
  output logic             interlock_active,
  output logic      [31:0] threshold_select,
  output logic             differential_mode,
  output logic      [15:0] out_special,
  output logic      [15:0] out_level,
  output logic             capture_pulse
);

  dic_pkg::dic_top_state_t s_reg;
  dic_pkg::dic_top_state_t s_next;
  dic_cap_if               cap_bus ();

  logic [31:0] inverted;
  logic [31:0] conditioned;
  logic [31:0] routed;
  logic [7:0]  sel;
  logic        hit;
  logic        is_wr;
  logic        is_rd;
  logic [4:0]  route_idx;

  // ************************************************************
  // input conditioning chain
  // ************************************************************
  always_comb begin
    // clock and direction inputs bypass the invert mask
    inverted    = s_reg.sync2 ^ (s_reg.invert & ~dic_pkg::CLKDIR_MASK);
    conditioned = (s_reg.force_en & s_reg.force_val)
                | (~s_reg.force_en & inverted);
    for (int b = 0; b < 32; b++) begin
      sel = s_reg.route_sel[b];
      // selector n in 1..32 picks conditioned input n-1; 0 and out of range give 0
      if (sel != 8'h00 && sel <= dic_pkg::ROUTE_ENTRIES) begin
        routed[b] = conditioned[5'(sel - 8'h01)];
      end else begin
        routed[b] = 1'b0;
      end
    end
  end

  // ************************************************************
  // object dictionary access and state update
  // ************************************************************
  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = din_pin;
    s_next.sync2 = s_reg.sync1;
    s_next.ack   = 1'b0;
    s_next.abort = 1'b0;
    s_next.rdata = dic_pkg::RST_WORD;
    is_wr        = od_req && od_wr;
    is_rd        = od_req && !od_wr;
    route_idx    = 5'(od_sub - 8'h01);
    hit          = 1'b1;
    cap_bus.ctrl_wr  = 1'b0;
    cap_bus.count_wr = 1'b0;
    cap_bus.user_wr  = 1'b0;
    cap_bus.raw_wr   = 1'b0;

    // routing switches the source of the whole word at once
    s_next.processed = s_reg.route_en[0] ? routed : conditioned;
    // special meanings read only bits 3:0 of the enable word
    s_next.special[dic_pkg::SFE_NEG_LIMIT] = s_reg.sfe[dic_pkg::SFE_NEG_LIMIT]
        & conditioned[dic_pkg::IN_NEG_LIMIT];
    s_next.special[dic_pkg::SFE_POS_LIMIT] = s_reg.sfe[dic_pkg::SFE_POS_LIMIT]
        & conditioned[dic_pkg::IN_POS_LIMIT];
    s_next.special[dic_pkg::SFE_HOME]      = s_reg.sfe[dic_pkg::SFE_HOME]
        & conditioned[dic_pkg::IN_HOME];
    s_next.special[dic_pkg::SFE_INTERLOCK] = s_reg.sfe[dic_pkg::SFE_INTERLOCK]
        & conditioned[dic_pkg::IN_INTERLOCK];

    if (od_index == dic_pkg::IDX_INPUT_CTRL) begin
      unique case (od_sub)
        dic_pkg::SUB_ENTRIES: begin
          s_next.rdata = {24'h00_0000, dic_pkg::INPUT_CTRL_ENTRIES};
          hit          = !is_wr;
        end
        dic_pkg::SUB_SFE: begin
          s_next.rdata = s_reg.sfe;
          if (is_wr) s_next.sfe = od_wdata;
        end
        dic_pkg::SUB_INVERT: begin
          s_next.rdata = s_reg.invert;
          if (is_wr) s_next.invert = od_wdata;
        end
        dic_pkg::SUB_FORCE_EN: begin
          s_next.rdata = s_reg.force_en;
          if (is_wr) s_next.force_en = od_wdata;
        end
        dic_pkg::SUB_FORCE_VAL: begin
          s_next.rdata = s_reg.force_val;
          if (is_wr) s_next.force_val = od_wdata;
        end
        dic_pkg::SUB_RAW: begin
          // writes are accepted but cannot overwrite live levels
          s_next.rdata = s_reg.sync2;
        end
        dic_pkg::SUB_RANGE: begin
          s_next.rdata = s_reg.range;
          if (is_wr) s_next.range = od_wdata;
        end
        dic_pkg::SUB_DIFF: begin
          s_next.rdata = s_reg.diff;
          if (is_wr) s_next.diff = od_wdata;
        end
        dic_pkg::SUB_ROUTE_EN: begin
          s_next.rdata = s_reg.route_en;
          if (is_wr) s_next.route_en = od_wdata;
        end
        default: hit = 1'b0;
      endcase
    end else if (od_index == dic_pkg::IDX_INPUT_ROUTE) begin
      if (od_sub == dic_pkg::SUB_ENTRIES) begin
        s_next.rdata = {24'h00_0000, dic_pkg::ROUTE_ENTRIES};
        hit          = !is_wr;
      end else if (od_sub <= dic_pkg::SUB_ROUTE_LAST) begin
        s_next.rdata = {24'h00_0000, s_reg.route_sel[route_idx]};
        if (is_wr) s_next.route_sel[route_idx] = od_wdata[7:0];
      end else begin
        hit = 1'b0;
      end
    end else if (od_index == dic_pkg::IDX_HOME_CAP) begin
      unique case (od_sub)
        dic_pkg::SUB_ENTRIES: begin
          s_next.rdata = {24'h00_0000, dic_pkg::CAP_ENTRIES};
          hit          = !is_wr;
        end
        dic_pkg::SUB_CAP_CTRL: begin
          s_next.rdata    = cap_bus.ctrl;
          cap_bus.ctrl_wr = is_wr && ce;
        end
        dic_pkg::SUB_CAP_COUNT: begin
          s_next.rdata     = cap_bus.count;
          cap_bus.count_wr = is_wr && ce;
        end
        dic_pkg::SUB_CAP_USER: begin
          s_next.rdata    = cap_bus.cap_user;
          cap_bus.user_wr = is_wr && ce;
        end
        dic_pkg::SUB_CAP_RAW: begin
          s_next.rdata   = cap_bus.cap_raw;
          cap_bus.raw_wr = is_wr && ce;
        end
        default: hit = 1'b0;
      endcase
    end else if (od_index == dic_pkg::IDX_OUTPUT_CTRL && od_sub == dic_pkg::SUB_OUT_LEVEL) begin
      s_next.rdata = s_reg.out_ctrl;
      if (is_wr) s_next.out_ctrl = od_wdata;
    end else begin
      hit = 1'b0;
    end

    if (od_req) begin
      s_next.ack   = hit;
      s_next.abort = !hit;
    end
    if (!is_rd || !hit) begin
      s_next.rdata = dic_pkg::RST_WORD;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg <= dic_pkg::TOP_STATE_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // homing capture
  // ************************************************************
  // home level is the enabled, conditioned home input, already registered
  assign cap_bus.home_level = s_reg.special[dic_pkg::SFE_HOME];
  assign cap_bus.pos_user   = pos_user;
  assign cap_bus.pos_raw    = pos_raw;
  assign cap_bus.wdata      = od_wdata;

  dic_home_capture u_capture (
    .clock  (clock),
    .resetn (resetn),
    .ce     (ce),
    .cap    (cap_bus.unit)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign od_rdata             = s_reg.rdata;
  assign od_ack               = s_reg.ack;
  assign od_abort             = s_reg.abort;
  assign processed_input_word = s_reg.processed;
  assign neg_limit_active     = s_reg.special[dic_pkg::SFE_NEG_LIMIT];
  assign pos_limit_active     = s_reg.special[dic_pkg::SFE_POS_LIMIT];
  assign home_active          = s_reg.special[dic_pkg::SFE_HOME];
  assign interlock_active     = s_reg.special[dic_pkg::SFE_INTERLOCK];
  assign threshold_select     = s_reg.range;
  assign differential_mode    = s_reg.diff[0];
  assign out_special          = s_reg.out_ctrl[dic_pkg::OUT_SPECIAL_LSB +: 16];
  assign out_level            = s_reg.out_ctrl[dic_pkg::OUT_LEVEL_LSB +: 16];
  assign capture_pulse        = cap_bus.pulse;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_raw_readback: assert property (ce && is_rd && od_index == dic_pkg::IDX_INPUT_CTRL
      && od_sub == dic_pkg::SUB_RAW |=> od_ack && od_rdata == $past(s_reg.sync2))
    else $error("raw read does not show input levels");
  a_invert_path: assert property (ce && s_reg.force_en == 32'h0000_0000 && !s_reg.route_en[0]
      |=> processed_input_word == ($past(s_reg.sync2)
      ^ ($past(s_reg.invert) & ~dic_pkg::CLKDIR_MASK)))
    else $error("inverted input word wrong");
  a_clkdir_plain: assert property (ce && !s_reg.route_en[0]
      && (s_reg.force_en & dic_pkg::CLKDIR_MASK) == 32'h0000_0000
      |=> (processed_input_word & dic_pkg::CLKDIR_MASK)
      == ($past(s_reg.sync2) & dic_pkg::CLKDIR_MASK))
    else $error("clock or direction input inverted");
  a_force_wins: assert property (ce && !s_reg.route_en[0]
      |=> (processed_input_word & $past(s_reg.force_en))
      == ($past(s_reg.force_val) & $past(s_reg.force_en)))
    else $error("forced bits not taken from force value");
  a_route_zero: assert property (ce && s_reg.route_en[0] && s_reg.route_sel[0] == 8'h00
      |=> !processed_input_word[0])
    else $error("unrouted bit not zero");
  a_route_first: assert property (ce && s_reg.route_en[0] && s_reg.route_sel[0] == 8'h03
      |=> processed_input_word[0] == $past(conditioned[2]))
    else $error("routed bit does not follow its source");
  a_sfe_gate: assert property (ce && !s_reg.sfe[dic_pkg::SFE_HOME] |=> !home_active)
    else $error("home active while disabled");
  a_threshold_wr: assert property (ce && is_wr && od_index == dic_pkg::IDX_INPUT_CTRL
      && od_sub == dic_pkg::SUB_RANGE |=> threshold_select == $past(od_wdata) && od_ack)
    else $error("threshold select not written");
  a_out_split: assert property (ce && is_wr && od_index == dic_pkg::IDX_OUTPUT_CTRL
      && od_sub == dic_pkg::SUB_OUT_LEVEL |=> out_level == $past(od_wdata[31:16])
      && out_special == $past(od_wdata[15:0]))
    else $error("output word halves misplaced");
  a_ro_abort: assert property (ce && is_wr && od_index == dic_pkg::IDX_INPUT_ROUTE
      && od_sub == dic_pkg::SUB_ENTRIES |=> od_abort && !od_ack)
    else $error("write to entry count not refused");

  c_routing_on: cover property (ce && s_reg.route_en[0] && od_ack);
  c_capture:    cover property (capture_pulse);
  c_forced:     cover property (ce && s_reg.force_en != 32'h0000_0000 && s_reg.invert != '0);

endmodule : dic_input_cond
`default_nettype wire

// File: dic_pkg.sv
`default_nettype none
package dic_pkg;

  // ************************************************************
  // object dictionary addressing
  // ************************************************************
  localparam logic [15:0] IDX_INPUT_CTRL  = 16'h3240;
  localparam logic [15:0] IDX_INPUT_ROUTE = 16'h3242;
  localparam logic [15:0] IDX_HOME_CAP    = 16'h3243;
  localparam logic [15:0] IDX_OUTPUT_CTRL = 16'h3250;

  localparam logic [7:0] SUB_ENTRIES   = 8'h00;
  localparam logic [7:0] SUB_SFE       = 8'h01;
  localparam logic [7:0] SUB_INVERT    = 8'h02;
  localparam logic [7:0] SUB_FORCE_EN  = 8'h03;
  localparam logic [7:0] SUB_FORCE_VAL = 8'h04;
  localparam logic [7:0] SUB_RAW       = 8'h05;
  localparam logic [7:0] SUB_RANGE     = 8'h06;
  localparam logic [7:0] SUB_DIFF      = 8'h07;
  localparam logic [7:0] SUB_ROUTE_EN  = 8'h08;
  localparam logic [7:0] SUB_CAP_CTRL  = 8'h01;
  localparam logic [7:0] SUB_CAP_COUNT = 8'h02;
  localparam logic [7:0] SUB_CAP_USER  = 8'h03;
  localparam logic [7:0] SUB_CAP_RAW   = 8'h04;
  localparam logic [7:0] SUB_OUT_LEVEL = 8'h04;
  localparam logic [7:0] SUB_ROUTE_LAST = 8'h20;

  localparam logic [7:0] INPUT_CTRL_ENTRIES = 8'h08;
  localparam logic [7:0] ROUTE_ENTRIES      = 8'h20;
  localparam logic [7:0] CAP_ENTRIES        = 8'h04;

  // ************************************************************
  // field positions and masks
  // ************************************************************
  localparam int unsigned SFE_NEG_LIMIT = 0;
  localparam int unsigned SFE_POS_LIMIT = 1;
  localparam int unsigned SFE_HOME      = 2;
  localparam int unsigned SFE_INTERLOCK = 3;
  localparam int unsigned IN_NEG_LIMIT  = 0;
  localparam int unsigned IN_POS_LIMIT  = 1;
  localparam int unsigned IN_HOME       = 2;
  localparam int unsigned IN_INTERLOCK  = 3;
  localparam logic [31:0] CLKDIR_MASK   = 32'h0000_0030;
  localparam int unsigned OUT_SPECIAL_LSB = 0;
  localparam int unsigned OUT_LEVEL_LSB   = 16;

  // ************************************************************
  // capture modes and state
  // ************************************************************
  typedef enum logic [1:0] {
    CAP_OFF  = 2'h0,
    CAP_RISE = 2'h1,
    CAP_FALL = 2'h2,
    CAP_BOTH = 2'h3
  } dic_cap_mode_t;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  RST_SEL  = 8'h00;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] count;
    logic [31:0] cap_user;
    logic [31:0] cap_raw;
    logic        home_q;
    logic        pulse;
  } dic_cap_state_t;

  typedef struct packed {
    logic [31:0]      sync1;
    logic [31:0]      sync2;
    logic [31:0]      sfe;
    logic [31:0]      invert;
    logic [31:0]      force_en;
    logic [31:0]      force_val;
    logic [31:0]      range;
    logic [31:0]      diff;
    logic [31:0]      route_en;
    logic [31:0][7:0] route_sel;
    logic [31:0]      out_ctrl;
    logic [31:0]      processed;
    logic [3:0]       special;
    logic [31:0]      rdata;
    logic             ack;
    logic             abort;
  } dic_top_state_t;

  localparam dic_cap_state_t CAP_STATE_RST = '0;
  localparam dic_top_state_t TOP_STATE_RST = '0;

endpackage : dic_pkg
`default_nettype wire

// File: dic_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: held switch levels and encoder, never a homing run
module dic_switch_model (
  input  wire logic        clock,
  input  wire logic [31:0] level_set,
  input  wire logic [31:0] pos_set,
  output logic      [31:0] din_pin,
  output logic      [31:0] pos_user,
  output logic      [31:0] pos_raw
);
  // lines settle one cycle after the command; raw differs from user on purpose
  always_ff @(posedge clock) begin
    din_pin  <= level_set;
    pos_user <= pos_set;
    pos_raw  <= ~pos_set;
  end
endmodule : dic_switch_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic        wr;
    logic [15:0] idx;
    logic [7:0]  sub;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        ab;
  } dic_row_t;
  logic        clock, resetn, ce, od_req, od_wr, od_ack, od_abort, diff, cap_p;
  logic        negl, posl, home, intl;
  logic [15:0] od_index, osp, olv;
  logic [7:0]  od_sub;
  logic [31:0] od_wdata, od_rdata, pwd, thr, lvl, pos, din, pu, pr;
  int          mismatches = 0;
  int          checks_done = 0;
  int          pulses = 0;
  logic [31:0] md [4] = '{32'h1, 32'h2, 32'h3, 32'h0};
  logic [31:0] cnt [4] = '{32'h1, 32'h1, 32'h2, 32'h2};
  dic_row_t    rows [12] = '{
    '{1'b0, 16'h3240, 8'h00, 32'h0, 32'h8, 1'b0},
    '{1'b0, 16'h3242, 8'h00, 32'h0, 32'h20, 1'b0},
    '{1'b0, 16'h3243, 8'h00, 32'h0, 32'h4, 1'b0},
    '{1'b1, 16'h3240, 8'h06, 32'ha5, 32'h0, 1'b0},
    '{1'b0, 16'h3240, 8'h06, 32'h0, 32'ha5, 1'b0},
    '{1'b0, 16'h3242, 8'h05, 32'h0, 32'h0, 1'b0},
    '{1'b1, 16'h3240, 8'h00, 32'h1, 32'h0, 1'b1},
    '{1'b0, 16'h3240, 8'h09, 32'h0, 32'h0, 1'b1},
    '{1'b1, 16'h3242, 8'h21, 32'h1, 32'h0, 1'b1},
    '{1'b1, 16'h3250, 8'h04, 32'h1234_5678, 32'h0, 1'b0},
    '{1'b1, 16'h3240, 8'h07, 32'h1, 32'h0, 1'b0},
    '{1'b0, 16'h3243, 8'h01, 32'h0, 32'h0, 1'b0}};

  dic_switch_model u_dic_switch_model (.clock(clock), .level_set(lvl), .pos_set(pos),
    .din_pin(din), .pos_user(pu), .pos_raw(pr));
  dic_input_cond u_dic_input_cond (.clock(clock), .resetn(resetn), .ce(ce), .din_pin(din),
    .pos_user(pu), .pos_raw(pr), .od_req(od_req), .od_wr(od_wr), .od_index(od_index),
    .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_abort(od_abort), .processed_input_word(pwd), .neg_limit_active(negl),
    .pos_limit_active(posl), .home_active(home), .interlock_active(intl),
    .threshold_select(thr), .differential_mode(diff), .out_special(osp),
    .out_level(olv), .capture_pulse(cap_p));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  // one access; answer is sampled 1 ns after the edge that takes the request
  task automatic od(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                    input logic [31:0] wd, input logic [31:0] rd, input logic ab);
    @(posedge clock);
    od_req   <= 1'b1;
    od_wr    <= w;
    od_index <= ix;
    od_sub   <= sb;
    od_wdata <= wd;
    @(posedge clock);
    od_req <= 1'b0;
    #1;
    chk32("ack", {31'h0, ~ab}, {31'h0, od_ack});
    chk32("abort", {31'h0, ab}, {31'h0, od_abort});
    chk32("rdata", rd, od_rdata);
  endtask : od

  task automatic settle;
    repeat (6) @(posedge clock);
    #1;
  endtask : settle

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  always @(posedge clock) begin
    if (cap_p === 1'b1) pulses++;
  end

  // hang cutter
  initial begin
    repeat (4000) @(posedge clock);
    mismatches++;
    final_report();
  end

  initial begin
    {resetn, od_req, od_wr, od_index, od_sub, od_wdata, lvl, pos} = '0;
    ce <= 1'b1;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    settle();
    chk32("processed", 32'h0, pwd);
    foreach (rows[i]) od(rows[i].wr, rows[i].idx, rows[i].sub, rows[i].wd, rows[i].rd, rows[i].ab);
    chk32("threshold", 32'ha5, thr);
    chk32("outctrl", 32'h1234_5678, {olv, osp});
    chk32("diff", 32'h1, {31'h0, diff});
    $display("test table done");
    lvl <= 32'hf1;
    od(1'b1, 16'h3240, 8'h02, 32'hff, 32'h0, 1'b0);
    settle();
    chk32("processed", 32'h3e, pwd);
    od(1'b0, 16'h3240, 8'h05, 32'h0, 32'hf1, 1'b0);
    od(1'b1, 16'h3240, 8'h04, 32'h1, 32'h0, 1'b0);
    od(1'b1, 16'h3240, 8'h03, 32'h3, 32'h0, 1'b0);
    settle();
    chk32("processed", 32'h3d, pwd);
    $display("test chain done");
    od(1'b1, 16'h3240, 8'h01, 32'hf, 32'h0, 1'b0);
    settle();
    chk32("special", 32'hd, {28'h0, intl, home, posl, negl});
    od(1'b1, 16'h3240, 8'h01, 32'hffff_0004, 32'h0, 1'b0);
    settle();
    chk32("special", 32'h4, {28'h0, intl, home, posl, negl});
    od(1'b1, 16'h3242, 8'h01, 32'h3, 32'h0, 1'b0);
    od(1'b1, 16'h3240, 8'h08, 32'h1, 32'h0, 1'b0);
    settle();
    chk32("routed", 32'h1, pwd);
    od(1'b1, 16'h3240, 8'h08, 32'h0, 32'h0, 1'b0);
    $display("test special done");
    pos <= 32'h1111_2222;
    od(1'b1, 16'h3240, 8'h03, 32'h7, 32'h0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      od(1'b1, 16'h3243, 8'h01, md[m], 32'h0, 1'b0);
      od(1'b1, 16'h3240, 8'h04, 32'h5, 32'h0, 1'b0);
      settle();
      od(1'b1, 16'h3240, 8'h04, 32'h1, 32'h0, 1'b0);
      settle();
      od(1'b0, 16'h3243, 8'h02, 32'h0, cnt[m], 1'b0);
    end
    od(1'b0, 16'h3243, 8'h03, 32'h0, 32'h1111_2222, 1'b0);
    od(1'b0, 16'h3243, 8'h04, 32'h0, 32'heeee_dddd, 1'b0);
    chk32("pulses", 32'h4, 32'(pulses));
    $display("test capture done");
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    settle();
    chk32("threshold", 32'h0, thr);
    od(1'b0, 16'h3243, 8'h02, 32'h0, 32'h0, 1'b0);
    od(1'b0, 16'h3242, 8'h01, 32'h0, 32'h0, 1'b0);
    $display("test reset done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
